/* File: inc/can_fc_pkg.sv */
// Constants for the bit timing, fault confinement and time stamp block
// Function
// - Three byte registers hold bit timing
// - Quantum clock divides by prescaler plus one
// - Processing time three quanta, else two
// - Second phase two delays transmit one quantum
// - Under ten clocks per bit is flagged
// - Separate byte transmit and receive counters
// - Step eight, receive one or eight, floor zero
// - Reset clears both error counters
// - Counters writable only in test, freeze, halt
// - Any counter at 128 gives passive
// - Both at 127 or below gives active
// - Transmit overflow enters bus off, clears counter
// - Eleven recessive bits step recovery count
// - Acknowledge errors never cause bus off
// - Receive counter stops, reloads on success
// - Flag type and bus drive follow state
// - Timer sampled at identifier, stored per frame
// - Optional timer clear on buffer zero
// - Mask bit one compares, zero ignores
// - Global mask below fourteen, own masks for fourteen and fifteen
package can_fc_pkg;
  // Register byte addresses
  localparam logic [7:0] OFF_PRESCALE = 8'h00;
  localparam logic [7:0] OFF_CTRL1 = 8'h04;
  localparam logic [7:0] OFF_CTRL2 = 8'h08;
  localparam logic [7:0] OFF_MODE = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_TEC = 8'h14;
  localparam logic [7:0] OFF_REC = 8'h18;
  localparam logic [7:0] OFF_TIMER = 8'h1c;
  localparam logic [7:0] OFF_GMASK = 8'h20;
  localparam logic [7:0] OFF_MASK14 = 8'h24;
  localparam logic [7:0] OFF_MASK15 = 8'h28;
  localparam logic [7:0] OFF_RX_STAMP = 8'h2c;
  localparam logic [7:0] OFF_TX_STAMP = 8'h30;
  // Field positions
  localparam int PROP_MSB = 2;
  localparam int PH1_MSB = 5;
  localparam int PH1_LSB = 3;
  localparam int PH2_MSB = 2;
  localparam int MODE_HALT = 0;
  localparam int MODE_FRZ = 1;
  localparam int MODE_TEST = 2;
  localparam int MODE_TSYNC = 3;
  localparam int ST_SHORT = 2;
  // Reset values
  localparam logic [7:0] MODE_RST = 8'h01;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [28:0] MASK_RST = 29'h1fffffff;
  // Fault confinement
  typedef enum logic [1:0] {
    CS_ACTIVE = 2'b00,
    CS_PASSIVE = 2'b01,
    CS_BUSOFF = 2'b10
  } conf_state_t;
  localparam logic [8:0] TEC_STEP = 9'h008;
  localparam logic [8:0] REC_STEP1 = 9'h001;
  localparam logic [7:0] PASS_LVL = 8'h80;
  localparam logic [7:0] PASS_MAX = 8'h7f;
  localparam logic [7:0] RECOV_DONE = 8'h80;
  localparam logic [7:0] REC_RELOAD = 8'h77;
  localparam logic [3:0] RUN_LAST = 4'ha;
  // Timing
  localparam logic [1:0] PROC_ONE_CLK = 2'h3;
  localparam logic [1:0] PROC_MULTI = 2'h2;
  localparam logic [2:0] PH2_LATE = 3'h2;
  localparam logic [5:0] SEG_FIXED = 6'h04;
  localparam logic [14:0] BIT_CLK_SAFE = 15'h000a;
  // Buffer numbers
  localparam logic [3:0] MB_SYNC = 4'h0;
  localparam logic [3:0] MB_OWN14 = 4'he;
  localparam logic [3:0] MB_OWN15 = 4'hf;

  function automatic logic [7:0] sat8(input logic [8:0] s);
    sat8 = s[8] ? 8'hff : s[7:0];
  endfunction : sat8
endpackage : can_fc_pkg

/* File: hdl/tq_prescaler.sv */
// Time quantum tick generator
`timescale 1ns/100ps
module tq_prescaler (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Divide value and tick
  input wire logic [7:0] div,
  output logic tick
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  // One tick every div plus one clocks
  always_comb
  begin
    cnt_nxt = cnt_r + 8'h01;
    tick_nxt = 1'b0;
    if (cnt_r >= div)
    begin
      cnt_nxt = 8'h00;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= 8'h00;
      tick_r <= 1'b0;
    end
    else if (ce)
    begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

  tick_every_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) && ce && $past(ce) && div == 8'h00 && $past(div) == 8'h00 |-> tick_r)
    else $error("quantum tick missing at divide one");
endmodule : tq_prescaler

/* File: hdl/acc_match.sv */
// Masked identifier comparison
`timescale 1ns/100ps
module acc_match (
  // Identifiers and mask
  input wire logic [28:0] id_in,
  input wire logic [28:0] id_ref,
  input wire logic [28:0] mask,
  // Result
  output logic hit
);
  // Only bits with mask one take part
  assign hit = ((id_in ^ id_ref) & mask) == 29'h00000000;
endmodule : acc_match

/* File: hdl/can_fault_conf.sv */
// Bit timing, fault confinement and time stamp block with APB registers
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/100ps
module can_fault_conf (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Protocol events
  input wire logic tx_err_ev,
  input wire logic ack_err_ev,
  input wire logic rx_err1_ev,
  input wire logic rx_err8_ev,
  input wire logic tx_ok_ev,
  input wire logic rx_ok_ev,
  input wire logic bit_valid,
  input wire logic bit_level,
  // Frame storage
  input wire logic id_start,
  input wire logic rx_store,
  input wire logic [3:0] rx_mb,
  input wire logic [28:0] rx_id,
  input wire logic [28:0] ref_id,
  // Status to the protocol engine
  output logic tq_tick,
  output logic [1:0] info_processing_time,
  output logic tx_late,
  output logic [1:0] fault_confinement_state,
  output logic active_flags,
  output logic bus_drive_en,
  output logic busoff_event,
  output logic id_match,
  output logic [15:0] stamp
);
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic [7:0] prescale_r, prescale_nxt;
  logic [7:0] ctrl1_r, ctrl1_nxt;
  logic [7:0] ctrl2_r, ctrl2_nxt;
  logic [7:0] mode_r, mode_nxt;
  logic [28:0] gmask_r, gmask_nxt;
  logic [28:0] mask14_r, mask14_nxt;
  logic [28:0] mask15_r, mask15_nxt;
  logic [7:0] tec_r, tec_nxt;
  logic [7:0] rec_r, rec_nxt;
  logic [3:0] run_r, run_nxt;
  can_fc_pkg::conf_state_t state_r, state_nxt;
  logic boff_r, boff_nxt;
  logic [15:0] timer_r, timer_nxt;
  logic [15:0] cap_r, cap_nxt;
  logic [15:0] rx_stamp_r, rx_stamp_nxt;
  logic [15:0] tx_stamp_r, tx_stamp_nxt;
  logic [1:0] proc_r, proc_nxt;
  logic late_r, late_nxt;
  logic short_r, short_nxt;
  logic aflag_r, aflag_nxt;
  logic drive_r, drive_nxt;
  logic match_r, match_nxt;
  logic wr_en, sw_mode, tec_wr, rec_wr, hit, unmapped;
  logic [8:0] tsum;
  logic [8:0] rsum;
  logic [28:0] mask_sel;
  logic [14:0] bit_clks;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  tq_prescaler u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .div(prescale_r),
    .tick(tq_tick)
  );

  // Global mask for buffers below fourteen
  always_comb
  begin
    case (rx_mb)
      can_fc_pkg::MB_OWN14: mask_sel = mask14_r;
      can_fc_pkg::MB_OWN15: mask_sel = mask15_r;
      default: mask_sel = gmask_r;
    endcase
  end

  acc_match u_match (
    .id_in(rx_id),
    .id_ref(ref_id),
    .mask(mask_sel),
    .hit(hit)
  );

  assign wr_en = psel && penable && pwrite && pready_r;
  assign sw_mode = mode_r[can_fc_pkg::MODE_HALT] || mode_r[can_fc_pkg::MODE_FRZ]
    || mode_r[can_fc_pkg::MODE_TEST];
  assign tec_wr = wr_en && sw_mode && paddr == can_fc_pkg::OFF_TEC;
  assign rec_wr = wr_en && sw_mode && paddr == can_fc_pkg::OFF_REC;

  // Bus slave and configuration
  always_comb
  begin
    pready_nxt = psel && !penable;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    prescale_nxt = prescale_r;
    ctrl1_nxt = ctrl1_r;
    ctrl2_nxt = ctrl2_r;
    mode_nxt = mode_r;
    gmask_nxt = gmask_r;
    mask14_nxt = mask14_r;
    mask15_nxt = mask15_r;
    unmapped = 1'b0;
    if (psel && !penable)
    begin
      prdata_nxt = 32'h00000000;
      case (paddr)
        can_fc_pkg::OFF_PRESCALE: prdata_nxt[7:0] = prescale_r;
        can_fc_pkg::OFF_CTRL1: prdata_nxt[7:0] = ctrl1_r;
        can_fc_pkg::OFF_CTRL2: prdata_nxt[7:0] = ctrl2_r;
        can_fc_pkg::OFF_MODE: prdata_nxt[7:0] = mode_r;
        can_fc_pkg::OFF_STATUS:
        begin
          prdata_nxt[1:0] = state_r;
          prdata_nxt[can_fc_pkg::ST_SHORT] = short_r;
        end
        can_fc_pkg::OFF_TEC: prdata_nxt[7:0] = tec_r;
        can_fc_pkg::OFF_REC: prdata_nxt[7:0] = rec_r;
        can_fc_pkg::OFF_TIMER: prdata_nxt[15:0] = timer_r;
        can_fc_pkg::OFF_GMASK: prdata_nxt[28:0] = gmask_r;
        can_fc_pkg::OFF_MASK14: prdata_nxt[28:0] = mask14_r;
        can_fc_pkg::OFF_MASK15: prdata_nxt[28:0] = mask15_r;
        can_fc_pkg::OFF_RX_STAMP: prdata_nxt[15:0] = rx_stamp_r;
        can_fc_pkg::OFF_TX_STAMP: prdata_nxt[15:0] = tx_stamp_r;
        default: unmapped = 1'b1;
      endcase
      pslverr_nxt = unmapped;
    end
    if (wr_en && !pslverr_r)
    begin
      case (paddr)
        can_fc_pkg::OFF_PRESCALE: prescale_nxt = pwdata[7:0];
        can_fc_pkg::OFF_CTRL1: ctrl1_nxt = pwdata[7:0];
        can_fc_pkg::OFF_CTRL2: ctrl2_nxt = pwdata[7:0];
        can_fc_pkg::OFF_MODE: mode_nxt = pwdata[7:0];
        can_fc_pkg::OFF_GMASK: gmask_nxt = pwdata[28:0];
        can_fc_pkg::OFF_MASK14: mask14_nxt = pwdata[28:0];
        can_fc_pkg::OFF_MASK15: mask15_nxt = pwdata[28:0];
        default: mode_nxt = mode_r;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
      prescale_r <= can_fc_pkg::BYTE_RST;
      ctrl1_r <= can_fc_pkg::BYTE_RST;
      ctrl2_r <= can_fc_pkg::BYTE_RST;
      mode_r <= can_fc_pkg::MODE_RST;
      gmask_r <= can_fc_pkg::MASK_RST;
      mask14_r <= can_fc_pkg::MASK_RST;
      mask15_r <= can_fc_pkg::MASK_RST;
    end
    else if (ce)
    begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      prescale_r <= prescale_nxt;
      ctrl1_r <= ctrl1_nxt;
      ctrl2_r <= ctrl2_nxt;
      mode_r <= mode_nxt;
      gmask_r <= gmask_nxt;
      mask14_r <= mask14_nxt;
      mask15_r <= mask15_nxt;
    end
  end

  // Error counters and confinement state
  always_comb
  begin
    tec_nxt = tec_r;
    rec_nxt = rec_r;
    run_nxt = run_r;
    state_nxt = state_r;
    boff_nxt = 1'b0;
    tsum = {1'b0, tec_r} + can_fc_pkg::TEC_STEP;
    rsum = {1'b0, rec_r} + (rx_err8_ev ? can_fc_pkg::TEC_STEP : can_fc_pkg::REC_STEP1);
    if (state_r == can_fc_pkg::CS_BUSOFF)
    begin
      if (bit_valid)
      begin
        if (!bit_level)
          run_nxt = 4'h0;
        else if (run_r == can_fc_pkg::RUN_LAST)
        begin
          run_nxt = 4'h0;
          tec_nxt = tec_r + 8'h01;
          if (tec_nxt == can_fc_pkg::RECOV_DONE)
          begin
            state_nxt = can_fc_pkg::CS_ACTIVE;
            tec_nxt = 8'h00;
            rec_nxt = 8'h00;
          end
        end
        else
          run_nxt = run_r + 4'h1;
      end
    end
    else
    begin
      if (tx_err_ev)
      begin
        if (tsum[8] && !ack_err_ev)
        begin
          state_nxt = can_fc_pkg::CS_BUSOFF;
          tec_nxt = 8'h00;
          run_nxt = 4'h0;
          boff_nxt = 1'b1;
        end
        else
          tec_nxt = can_fc_pkg::sat8(tsum);
      end
      else if (tx_ok_ev && tec_r != 8'h00)
        tec_nxt = tec_r - 8'h01;
      if ((rx_err1_ev || rx_err8_ev) && rec_r <= can_fc_pkg::PASS_MAX)
        rec_nxt = can_fc_pkg::sat8(rsum);
      else if (rx_ok_ev && rec_r > can_fc_pkg::PASS_MAX)
        rec_nxt = can_fc_pkg::REC_RELOAD;
      else if (rx_ok_ev && rec_r != 8'h00)
        rec_nxt = rec_r - 8'h01;
    end
    if (tec_wr)
      tec_nxt = pwdata[7:0];
    if (rec_wr)
      rec_nxt = pwdata[7:0];
    if (state_r != can_fc_pkg::CS_BUSOFF && state_nxt != can_fc_pkg::CS_BUSOFF)
    begin
      if (tec_nxt >= can_fc_pkg::PASS_LVL || rec_nxt >= can_fc_pkg::PASS_LVL)
        state_nxt = can_fc_pkg::CS_PASSIVE;
      else
        state_nxt = can_fc_pkg::CS_ACTIVE;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tec_r <= 8'h00;
      rec_r <= 8'h00;
      run_r <= 4'h0;
      state_r <= can_fc_pkg::CS_ACTIVE;
      boff_r <= 1'b0;
    end
    else if (ce)
    begin
      tec_r <= tec_nxt;
      rec_r <= rec_nxt;
      run_r <= run_nxt;
      state_r <= state_nxt;
      boff_r <= boff_nxt;
    end
  end

  // Timing status, time stamp and match
  function automatic logic [5:0] seg_sum(input logic [2:0] p, input logic [7:0] c2);
    seg_sum = can_fc_pkg::SEG_FIXED + {3'h0, p} + {3'h0, c2[can_fc_pkg::PH1_MSB:can_fc_pkg::PH1_LSB]}
      + {3'h0, c2[can_fc_pkg::PH2_MSB:0]};
  endfunction : seg_sum

  assign bit_clks = 15'({7'h00, prescale_r} + 15'h0001)
    * 15'(seg_sum(ctrl1_r[can_fc_pkg::PROP_MSB:0], ctrl2_r));

  always_comb
  begin
    proc_nxt = (prescale_r == 8'h00) ? can_fc_pkg::PROC_ONE_CLK : can_fc_pkg::PROC_MULTI;
    late_nxt = ctrl2_r[can_fc_pkg::PH2_MSB:0] == can_fc_pkg::PH2_LATE;
    short_nxt = bit_clks < can_fc_pkg::BIT_CLK_SAFE;
    aflag_nxt = state_nxt == can_fc_pkg::CS_ACTIVE;
    drive_nxt = state_nxt != can_fc_pkg::CS_BUSOFF;
    match_nxt = hit;
    timer_nxt = timer_r + {15'h0000, bit_valid};
    cap_nxt = id_start ? timer_r : cap_r;
    rx_stamp_nxt = rx_store ? cap_r : rx_stamp_r;
    tx_stamp_nxt = tx_ok_ev ? cap_r : tx_stamp_r;
    if (rx_store && rx_mb == can_fc_pkg::MB_SYNC && mode_r[can_fc_pkg::MODE_TSYNC])
      timer_nxt = 16'h0000;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      proc_r <= can_fc_pkg::PROC_ONE_CLK;
      late_r <= 1'b0;
      short_r <= 1'b1;
      aflag_r <= 1'b1;
      drive_r <= 1'b1;
      match_r <= 1'b0;
      timer_r <= 16'h0000;
      cap_r <= 16'h0000;
      rx_stamp_r <= 16'h0000;
      tx_stamp_r <= 16'h0000;
    end
    else if (ce)
    begin
      proc_r <= proc_nxt;
      late_r <= late_nxt;
      short_r <= short_nxt;
      aflag_r <= aflag_nxt;
      drive_r <= drive_nxt;
      match_r <= match_nxt;
      timer_r <= timer_nxt;
      cap_r <= cap_nxt;
      rx_stamp_r <= rx_stamp_nxt;
      tx_stamp_r <= tx_stamp_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign info_processing_time = proc_r;
  assign tx_late = late_r;
  assign fault_confinement_state = state_r;
  assign active_flags = aflag_r;
  assign bus_drive_en = drive_r;
  assign busoff_event = boff_r;
  assign id_match = match_r;
  assign stamp = rx_stamp_r;

  busoff_entry_a: assert property (ce && tx_err_ev && !ack_err_ev && !tec_wr
    && state_r != can_fc_pkg::CS_BUSOFF && tec_r > 8'hf7
    |=> state_r == can_fc_pkg::CS_BUSOFF && tec_r == 8'h00 && busoff_event)
    else $error("transmit overflow did not enter bus off");
  passive_level_a: assert property (state_r == can_fc_pkg::CS_ACTIVE
    |-> tec_r < can_fc_pkg::PASS_LVL && rec_r < can_fc_pkg::PASS_LVL)
    else $error("active state with a counter at 128");
  active_return_a: assert property (ce && state_r == can_fc_pkg::CS_PASSIVE && !tx_err_ev
    && !rx_err1_ev && !rx_err8_ev && !tec_wr && !rec_wr && tec_r < 8'h80 && rec_r == 8'h80 && rx_ok_ev
    |=> state_r == can_fc_pkg::CS_ACTIVE && active_flags)
    else $error("no return to active");
  ack_no_busoff_a: assert property (ce && tx_err_ev && ack_err_ev
    && state_r == can_fc_pkg::CS_PASSIVE |=> state_r != can_fc_pkg::CS_BUSOFF)
    else $error("acknowledge error caused bus off");
  rec_stop_a: assert property (ce && rec_r > 8'h7f && rx_err8_ev && !rx_ok_ev
    && !rec_wr && state_r != can_fc_pkg::CS_BUSOFF |=> $stable(rec_r))
    else $error("receive counter moved above 127");
  rec_reload_a: assert property (ce && rx_ok_ev && rec_r > 8'h7f && !rx_err1_ev && !rx_err8_ev
    && !rec_wr && state_r != can_fc_pkg::CS_BUSOFF |=> rec_r == can_fc_pkg::REC_RELOAD)
    else $error("receive counter not reloaded");
  run_restart_a: assert property (ce && state_r == can_fc_pkg::CS_BUSOFF && bit_valid
    && !bit_level && !tec_wr |=> run_r == 4'h0 && tec_r == $past(tec_r))
    else $error("dominant bit did not restart run");
  drive_off_a: assert property (ce && state_r == can_fc_pkg::CS_BUSOFF && !bit_valid
    |=> !bus_drive_en)
    else $error("bus driven while bus off");
  stamp_path_a: assert property (ce && id_start ##1 ce && rx_store
    |=> stamp == $past(timer_r, 2))
    else $error("stored stamp differs from sampled timer");
endmodule : can_fault_conf

/* File: tb/can_node_model.sv */
// Model of the other bus nodes, delivering one bus bit every two clocks
`timescale 1ns/100ps
module can_node_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bit stream control
  input wire logic run,
  input wire logic dom,
  // Bit stream out
  output logic bit_valid,
  output logic bit_level
);
  logic bit_valid_r;
  logic bit_valid_nxt;
  logic bit_level_r;
  logic bit_level_nxt;

  always_comb
  begin
    bit_valid_nxt = run ? ~bit_valid_r : 1'b0;
    // Released bus returns to recessive
    bit_level_nxt = run ? ~dom : 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bit_valid_r <= 1'b0;
      bit_level_r <= 1'b1;
    end
    else
    begin
      bit_valid_r <= bit_valid_nxt;
      bit_level_r <= bit_level_nxt;
    end
  end

  assign bit_valid = bit_valid_r;
  assign bit_level = bit_level_r;
endmodule : can_node_model

/* File: tb/can_fault_conf_bench.sv */
// Bench for the bit timing, fault confinement and time stamp block
`timescale 1ns/100ps
module can_fault_conf_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] ev = 8'h00;
  logic [3:0] rx_mb = 4'h0;
  logic [28:0] rx_id = 29'h0;
  logic [28:0] ref_id = 29'h0;
  logic run = 1'b0;
  logic dom = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, tq_tick, tx_late, active_flags, bus_drive_en, busoff_event, id_match;
  logic [1:0] proc_tq;
  logic [1:0] conf_state;
  logic [15:0] stamp;
  logic bit_valid, bit_level;
  logic [31:0] rdat;
  logic rerr;
  int n_mismatch = 0;
  int total_checks = 0;
  int k;

  always #5 pclk = ~pclk;

  can_node_model node (.pclk(pclk), .presetn(presetn), .run(run), .dom(dom), .bit_valid(bit_valid),
    .bit_level(bit_level));

  can_fault_conf DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_err_ev(ev[0]), .ack_err_ev(ev[1]), .rx_err1_ev(ev[2]), .rx_err8_ev(ev[3]), .tx_ok_ev(ev[4]),
    .rx_ok_ev(ev[5]), .bit_valid(bit_valid), .bit_level(bit_level), .id_start(ev[6]), .rx_store(ev[7]),
    .rx_mb(rx_mb), .rx_id(rx_id), .ref_id(ref_id), .tq_tick(tq_tick), .info_processing_time(proc_tq),
    .tx_late(tx_late), .fault_confinement_state(conf_state), .active_flags(active_flags),
    .bus_drive_en(bus_drive_en), .busoff_event(busoff_event),
    .id_match(id_match), .stamp(stamp));

  task stop_test;
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      n_mismatch++;
      stop_test();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rdat, exp);
  endtask : rd

  // One-cycle event pulses, spaced apart
  task fire(input logic [7:0] v, input int n);
    repeat (n)
    begin
      @(posedge pclk);
      ev <= v;
      @(posedge pclk);
      ev <= 8'h00;
    end
    repeat (3) @(posedge pclk);
  endtask : fire

  // Let the bus deliver n bits of one level
  task bits(input int n, input logic d);
    int c;
    int t;
    dom <= d;
    run <= 1'b1;
    c = 0;
    t = 0;
    while (c < n && t < 40000)
    begin
      @(posedge pclk);
      t++;
      if (bit_valid === 1'b1)
        c++;
    end
    if (t >= 40000)
    begin
      n_mismatch++;
      stop_test();
    end
    run <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : bits

  task mt(input logic [3:0] mb, input logic exp);
    rx_mb <= mb;
    repeat (3) @(posedge pclk);
    chk("id_match", id_match, exp);
  endtask : mt

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("proc time", proc_tq, 3);
    chk("drive", bus_drive_en & active_flags, 1);
    rd(can_fc_pkg::OFF_TEC, 0, "tec");
    rd(can_fc_pkg::OFF_REC, 0, "rec");
    rd(can_fc_pkg::OFF_MODE, 1, "mode");
    rd(can_fc_pkg::OFF_STATUS, 4, "status");
    wr(can_fc_pkg::OFF_CTRL1, 2);
    wr(can_fc_pkg::OFF_CTRL2, 8'h0a);
    rd(can_fc_pkg::OFF_CTRL2, 8'h0a, "ctrl2");
    rd(can_fc_pkg::OFF_STATUS, 4, "status");
    chk("tx_late", tx_late, 1);
    wr(can_fc_pkg::OFF_PRESCALE, 3);
    rd(can_fc_pkg::OFF_STATUS, 0, "status");
    chk("proc time", proc_tq, 2);
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (tq_tick !== 1'b1 && k < 20);
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (tq_tick !== 1'b1 && k < 20);
    chk("tick gap", k, 4);
    wr(can_fc_pkg::OFF_CTRL2, 8'h0b);
    rd(can_fc_pkg::OFF_PRESCALE, 3, "prescale");
    chk("tx_late", tx_late, 0);
    rd(8'h40, 0, "unmapped");
    chk("pslverr", rerr, 1);
    wr(can_fc_pkg::OFF_MODE, 0);
    fire(8'h04, 1);
    rd(can_fc_pkg::OFF_REC, 1, "rec");
    fire(8'h20, 2);
    rd(can_fc_pkg::OFF_REC, 0, "rec");
    ce <= 1'b0;
    fire(8'h08, 1);
    ce <= 1'b1;
    rd(can_fc_pkg::OFF_REC, 0, "rec frozen");
    fire(8'h08, 16);
    rd(can_fc_pkg::OFF_STATUS, 1, "status");
    fire(8'h08, 1);
    rd(can_fc_pkg::OFF_REC, 8'h80, "rec");
    fire(8'h20, 1);
    rd(can_fc_pkg::OFF_REC, 8'h77, "rec");
    rd(can_fc_pkg::OFF_STATUS, 0, "status");
    wr(can_fc_pkg::OFF_MODE, 1);
    wr(can_fc_pkg::OFF_TEC, 8'h78);
    rd(can_fc_pkg::OFF_TEC, 8'h78, "tec");
    wr(can_fc_pkg::OFF_MODE, 0);
    wr(can_fc_pkg::OFF_TEC, 8'h10);
    rd(can_fc_pkg::OFF_TEC, 8'h78, "tec");
    fire(8'h01, 1);
    rd(can_fc_pkg::OFF_STATUS, 1, "status");
    chk("active_flags", active_flags, 0);
    fire(8'h10, 1);
    rd(can_fc_pkg::OFF_TEC, 8'h7f, "tec");
    rd(can_fc_pkg::OFF_STATUS, 0, "status");
    fire(8'h01, 1);
    fire(8'h03, 16);
    rd(can_fc_pkg::OFF_TEC, 8'hff, "tec");
    rd(can_fc_pkg::OFF_STATUS, 1, "status");
    @(posedge pclk);
    ev <= 8'h01;
    @(posedge pclk);
    ev <= 8'h00;
    @(posedge pclk);
    chk("busoff_event", busoff_event, 1);
    chk("conf_state", conf_state, 2);
    @(posedge pclk);
    chk("bus_drive_en", bus_drive_en, 0);
    rd(can_fc_pkg::OFF_TEC, 0, "tec");
    bits(5, 1'b0);
    bits(1, 1'b1);
    bits(10, 1'b0);
    rd(can_fc_pkg::OFF_TEC, 0, "tec");
    bits(1, 1'b0);
    rd(can_fc_pkg::OFF_TEC, 1, "tec");
    bits(1396, 1'b0);
    rd(can_fc_pkg::OFF_STATUS, 2, "status");
    bits(1, 1'b0);
    rd(can_fc_pkg::OFF_STATUS, 0, "status");
    rd(can_fc_pkg::OFF_REC, 0, "rec");
    chk("bus_drive_en", bus_drive_en, 1);
    wr(can_fc_pkg::OFF_MODE, 8'h08);
    fire(8'h80, 1);
    bits(5, 1'b0);
    fire(8'h40, 1);
    rx_mb <= 4'h3;
    fire(8'h80, 1);
    @(posedge pclk);
    ev <= 8'h40;
    @(posedge pclk);
    ev <= 8'h80;
    @(posedge pclk);
    ev <= 8'h00;
    repeat (2) @(posedge pclk);
    chk("stamp", stamp, 5);
    rd(can_fc_pkg::OFF_TIMER, 5, "timer");
    fire(8'h10, 1);
    rd(can_fc_pkg::OFF_TX_STAMP, 5, "tx stamp");
    rx_id <= 29'h1;
    mt(4'h3, 1'b0);
    wr(can_fc_pkg::OFF_GMASK, 29'h1ffffffe);
    mt(4'h3, 1'b1);
    mt(4'he, 1'b0);
    wr(can_fc_pkg::OFF_MASK14, 29'h1ffffffe);
    mt(4'he, 1'b1);
    mt(4'hf, 1'b0);
    stop_test();
  end
endmodule : can_fault_conf_bench
